//--- cuc_counter_ctl.sv
`timescale 1ns/100ps
`include "cuc_map.svh"
module cuc_counter_ctl
    import cuc_pkg::*;
(
    input  wire logic        i_clk,      // system clock, 100 MHz
    input  wire logic        i_arst_n,   // asynchronous reset, low active
    input  wire logic        i_psel,     // apb select
    input  wire logic        i_penable,  // apb access phase
    input  wire logic        i_pwrite,   // apb write
    input  wire logic [11:0] i_paddr,    // apb byte address
    input  wire logic [31:0] i_pwdata,   // apb write data
    output logic      [31:0] o_prdata,   // apb read data
    output logic             o_pready,   // apb ready
    output logic             o_pslverr,  // apb error, unmapped
    output logic             o_div_tick, // divider period pulse
    cuc_link_if.ctl          link        // pins toward counter
);

    // ============================================================
    // apb decode
    logic setup;
    logic wr_acc;
    logic mapped;

    assign setup  = i_psel && !i_penable;
    assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
    assign mapped = (i_paddr == `CUC_OFS_CTRL) ||
                    (i_paddr == `CUC_OFS_PRESET) ||
                    (i_paddr == `CUC_OFS_STATUS) ||
                    (i_paddr == `CUC_OFS_CMD);

    // ============================================================
    // observed counter state
    logic [3:0] cnt_seen;
    logic       term_ff;

    assign cnt_seen = {link.count_bit3, link.count_bit2,
                       link.count_bit1, link.count_bit0};

    // ============================================================
    // registers
    logic [2:0] ctrl_ff;
    logic [3:0] preset_ff;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff <= `CUC_CTRL_RST;
        end else if (wr_acc && i_paddr == `CUC_OFS_CTRL) begin
            ctrl_ff <= i_pwdata[2:0];
        end
    end

    // a zero ratio would leave the divider undefined
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            preset_ff <= `CUC_PRESET_RST;
        end else if (wr_acc && i_paddr == `CUC_OFS_PRESET &&
                     !(ctrl_ff[`CUC_CTRL_DIV] && i_pwdata[3:0] == 4'h0)) begin
            preset_ff <= i_pwdata[3:0];
        end
    end

    // sticky terminal flag, set wins over write-one clear
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            term_ff <= 1'b0;
        end else if (!link.carry_out_n) begin
            term_ff <= 1'b1;
        end else if (wr_acc && i_paddr == `CUC_OFS_STATUS &&
                     i_pwdata[`CUC_STAT_TERM]) begin
            term_ff <= 1'b0;
        end
    end

    // ============================================================
    // load and clear strobes, one cycle each
    logic div_on;
    logic load_ff;
    logic clear_ff;
    logic div_reload;

    assign div_on     = ctrl_ff[`CUC_CTRL_DIV] && preset_ff != 4'h0;
    assign div_reload = div_on && !load_ff && ctrl_ff[`CUC_CTRL_RUN] &&
                        (cnt_seen == `CUC_DIV_RELOAD_AT ||
                         cnt_seen == 4'h1);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            load_ff <= 1'b0;
        end else begin
            load_ff <= div_reload || (wr_acc && i_paddr == `CUC_OFS_CMD &&
                       i_pwdata[`CUC_CMD_LOAD]);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clear_ff <= 1'b0;
        end else begin
            clear_ff <= wr_acc && i_paddr == `CUC_OFS_CMD &&
                        i_pwdata[`CUC_CMD_CLEAR];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_div_tick <= 1'b0;
        end else begin
            o_div_tick <= div_reload;
        end
    end

    // ============================================================
    // apb answer: one access cycle, no waits
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup && !mapped;
            o_prdata  <= 32'h0000_0000;
            if (setup && !i_pwrite) begin
                case (i_paddr)
                    `CUC_OFS_CTRL: begin
                        o_prdata <= {29'h0, ctrl_ff};
                    end
                    `CUC_OFS_PRESET: begin
                        o_prdata <= {28'h0, preset_ff};
                    end
                    `CUC_OFS_STATUS: begin
                        o_prdata <= {25'h0, link.count_up, term_ff,
                                     link.carry_out_n, cnt_seen};
                    end
                    default: begin
                        o_prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // pins
    assign link.load_strobe     = load_ff;
    assign link.clear           = clear_ff;
    assign link.count_up        = ctrl_ff[`CUC_CTRL_UP] &&
                                  !ctrl_ff[`CUC_CTRL_DIV];
    assign link.carry_in_n      = !ctrl_ff[`CUC_CTRL_RUN];
    assign link.load_value_bit0 = preset_ff[0];
    assign link.load_value_bit1 = preset_ff[1];
    assign link.load_value_bit2 = preset_ff[2];
    assign link.load_value_bit3 = preset_ff[3];

endmodule

//--- cuc_map.svh
`ifndef CUC_MAP_SVH
`define CUC_MAP_SVH

// ============================================================
// counter stage
`define CUC_WIDTH          4
`define CUC_COUNT_RST      4'h0
`define CUC_COUNT_MAX      4'hf
`define CUC_COUNT_MIN      4'h0

// ============================================================
// controller register offsets (byte addresses)
`define CUC_OFS_CTRL       12'h000
`define CUC_OFS_PRESET     12'h004
`define CUC_OFS_STATUS     12'h008
`define CUC_OFS_CMD        12'h00c

// ============================================================
// field positions
`define CUC_CTRL_UP        0
`define CUC_CTRL_RUN       1
`define CUC_CTRL_DIV       2
`define CUC_CMD_LOAD       0
`define CUC_CMD_CLEAR      1
`define CUC_STAT_CARRY_N   4
`define CUC_STAT_TERM      5
`define CUC_STAT_DIR       6

// ============================================================
// reset values and divider reload point
`define CUC_CTRL_RST       3'h0
`define CUC_PRESET_RST     4'h0
`define CUC_DIV_RELOAD_AT  4'h2

`endif

//--- cuc_pkg.sv
package cuc_pkg;
    typedef enum logic [1:0] {
        CUC_ACT_HOLD,
        CUC_ACT_COUNT,
        CUC_ACT_LOAD,
        CUC_ACT_CLEAR
    } cuc_action_t;

    typedef enum logic {
        CUC_DIR_DOWN,
        CUC_DIR_UP
    } cuc_dir_t;
endpackage

//--- cuc_link_if.sv
`timescale 1ns/100ps
interface cuc_link_if;
    logic load_strobe;       // load request, high active
    logic clear;             // clear request, high active
    logic count_up;          // 1 up, 0 down
    logic carry_in_n;        // cascade enable, low active
    logic load_value_bit0;   // preset value lsb
    logic load_value_bit1;
    logic load_value_bit2;
    logic load_value_bit3;   // preset value msb
    logic count_bit0;        // count lsb
    logic count_bit1;
    logic count_bit2;
    logic count_bit3;        // count msb
    logic carry_out_n;       // terminal count, low active

    modport dev (
        input  load_strobe, clear, count_up, carry_in_n,
        input  load_value_bit0, load_value_bit1,
        input  load_value_bit2, load_value_bit3,
        output count_bit0, count_bit1, count_bit2, count_bit3,
        output carry_out_n
    );

    modport ctl (
        output load_strobe, clear, count_up, carry_in_n,
        output load_value_bit0, load_value_bit1,
        output load_value_bit2, load_value_bit3,
        input  count_bit0, count_bit1, count_bit2, count_bit3,
        input  carry_out_n
    );
endinterface

//--- cuc_counter_dev.sv
`timescale 1ns/100ps
`include "cuc_map.svh"
module cuc_counter_dev
    import cuc_pkg::*;
#(
    parameter int WIDTH = `CUC_WIDTH
) (
    input  wire logic i_clk,     // system clock, 100 MHz
    input  wire logic i_arst_n,  // asynchronous reset, low active
    cuc_link_if.dev   link       // pins toward controller
);

    // ============================================================
    // input gathering
    logic [WIDTH-1:0] preset_val;
    logic             enabled;
    cuc_dir_t         dir;
    cuc_action_t      action;

    assign preset_val = {link.load_value_bit3, link.load_value_bit2,
                         link.load_value_bit1, link.load_value_bit0};
    assign enabled    = ~link.carry_in_n;
    assign dir        = link.count_up ? CUC_DIR_UP : CUC_DIR_DOWN;

    // ============================================================
    // action select
    always_comb begin
        if (link.clear) begin
            action = CUC_ACT_CLEAR;
        end else if (link.load_strobe) begin
            action = CUC_ACT_LOAD;
        end else if (enabled) begin
            action = CUC_ACT_COUNT;
        end else begin
            action = CUC_ACT_HOLD;
        end
    end

    // ============================================================
    // next count
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic [WIDTH-1:0] step_val;

    always_comb begin
        if (dir == CUC_DIR_UP) begin
            step_val = count_ff + WIDTH'(1);
        end else begin
            step_val = count_ff - WIDTH'(1);
        end
    end

    always_comb begin
        case (action)
            CUC_ACT_CLEAR: begin
                nxt_count = WIDTH'(`CUC_COUNT_RST);
            end
            CUC_ACT_LOAD: begin
                nxt_count = preset_val;
            end
            CUC_ACT_COUNT: begin
                nxt_count = step_val;
            end
            CUC_ACT_HOLD: begin
                nxt_count = count_ff;
            end
            default: begin
                nxt_count = count_ff;
            end
        endcase
    end

    // ============================================================
    // count register
    // a load leaves the preset in place; the next enabled edge
    // with the strobe low steps from it
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_ff <= WIDTH'(`CUC_COUNT_RST);
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ============================================================
    // terminal count
    // looks ahead at the count after this edge so the output is a
    // flop and lines up with the cycle spent at the end value
    logic       nxt_at_end;
    logic       carry_out_n_ff;
    logic       nxt_carry_out_n;

    always_comb begin
        if (dir == CUC_DIR_UP) begin
            nxt_at_end = (nxt_count == WIDTH'(`CUC_COUNT_MAX));
        end else begin
            nxt_at_end = (nxt_count == WIDTH'(`CUC_COUNT_MIN));
        end
    end

    // clear and load block the carry as they block counting
    assign nxt_carry_out_n = ~(nxt_at_end && action == CUC_ACT_COUNT);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            carry_out_n_ff <= 1'b1;
        end else begin
            carry_out_n_ff <= nxt_carry_out_n;
        end
    end

    // ============================================================
    // pins
    assign link.count_bit0 = count_ff[0];
    assign link.count_bit1 = count_ff[1];
    assign link.count_bit2 = count_ff[2];
    assign link.count_bit3 = count_ff[3];
    assign link.carry_out_n = carry_out_n_ff;

endmodule

//--- cuc_link_properties.sv
`timescale 1ns/100ps
// ==========
// link checker
module cuc_link_properties (
    input wire logic i_clk,           // clock
    input wire logic i_arst_n,        // reset
    input wire logic load_strobe,     // load
    input wire logic clear,           // clear
    input wire logic count_up,        // direction
    input wire logic carry_in_n,      // enable
    input wire logic load_value_bit0, // preset
    input wire logic load_value_bit1, // preset
    input wire logic load_value_bit2, // preset
    input wire logic load_value_bit3, // preset
    input wire logic count_bit0,      // count
    input wire logic count_bit1,      // count
    input wire logic count_bit2,      // count
    input wire logic count_bit3,      // count
    input wire logic carry_out_n      // terminal
);
    logic [3:0] cnt;
    logic [3:0] pre;
    logic       step;
    assign cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
    assign pre = {load_value_bit3, load_value_bit2, load_value_bit1,
                  load_value_bit0};
    assign step = !clear && !load_strobe && !carry_in_n;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    sequence s_top;
        step && count_up && cnt == 4'he;
    endsequence
    sequence s_bot;
        step && !count_up && cnt == 4'h1;
    endsequence
    AST_LOAD: assert property (
        load_strobe && !clear |=> cnt == $past(pre)) else $error("no load");
    AST_CLEAR: assert property (
        clear |=> cnt == 4'h0 && carry_out_n) else $error("no clear");
    AST_BLOCK: assert property (
        load_strobe |=> carry_out_n) else $error("carry during load");
    AST_UP: assert property (
        step && count_up |=> cnt == $past(cnt) + 4'h1) else $error("up");
    AST_DOWN: assert property (
        step && !count_up |=> cnt == $past(cnt) - 4'h1) else $error("down");
    AST_HOLD: assert property (
        !clear && !load_strobe && carry_in_n |=> $stable(cnt))
        else $error("count moved while disabled");
    AST_TOP: assert property (
        s_top |=> !carry_out_n) else $error("no carry at top");
    AST_BOT: assert property (
        s_bot |=> !carry_out_n) else $error("no carry at bottom");
    AST_ONLY: assert property (
        !carry_out_n |-> $past(step)
            && cnt == ($past(count_up) ? 4'hf : 4'h0))
        else $error("carry without terminal count");
    AST_ONE: assert property (
        !carry_out_n |=> carry_out_n) else $error("carry too long");
endmodule

//--- cuc_counter4_test.sv
`timescale 1ns/100ps
`include "cuc_map.svh"
// ==========
// bench top
module cuc_counter4_test;
    logic        i_clk;
    logic        i_arst_n   = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        div_tick;
    logic [3:0]  cnt;
    logic [31:0] rd;
    logic        er;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          cyc        = 0;

    cuc_link_if link ();
    assign cnt = {link.count_bit3, link.count_bit2, link.count_bit1,
                  link.count_bit0};
    cuc_counter_dev i_cuc_counter_dev (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .link(link)
    );
    cuc_counter_ctl i_cuc_counter_ctl (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_div_tick(div_tick), .link(link)
    );
    cuc_link_properties i_cuc_link_properties (
        .i_clk(i_clk), .i_arst_n(i_arst_n),
        .load_strobe(link.load_strobe), .clear(link.clear),
        .count_up(link.count_up), .carry_in_n(link.carry_in_n),
        .load_value_bit0(link.load_value_bit0),
        .load_value_bit1(link.load_value_bit1),
        .load_value_bit2(link.load_value_bit2),
        .load_value_bit3(link.load_value_bit3),
        .count_bit0(link.count_bit0), .count_bit1(link.count_bit1),
        .count_bit2(link.count_bit2), .count_bit3(link.count_bit3),
        .carry_out_n(link.carry_out_n)
    );

    // ==========
    // clock and hang guard
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end

    // ==========
    // helpers
    task automatic close_out();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; idles one cycle after it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wait_co();
        do @(posedge i_clk); while (link.carry_out_n !== 1'b0);
    endtask

    // ==========
    // scenarios
    task automatic t_reset();
        apb(1'b0, `CUC_OFS_STATUS, 32'h0);
        cmp("idle status", 32'h10, rd);
        apb(1'b0, 12'h010, 32'h0);
        cmp("unmapped err", 32'h1, {31'h0, er});
        cmp("unmapped data", 32'h0, rd);
    endtask
    task automatic t_up();
        apb(1'b1, `CUC_OFS_PRESET, 32'he);
        apb(1'b1, `CUC_OFS_CMD, 32'h1);
        @(posedge i_clk);
        cmp("pins", 32'he, {28'h0, cnt});
        apb(1'b1, `CUC_OFS_CTRL, 32'h3);
        wait_co();
        cmp("top", 32'hf, {28'h0, cnt});
        @(posedge i_clk);
        cmp("wrap up", 32'h0, {28'h0, cnt});
        cmp("carry one", 32'h1, {31'h0, link.carry_out_n});
        apb(1'b1, `CUC_OFS_CTRL, 32'h1);
        apb(1'b1, `CUC_OFS_PRESET, 32'h9);
        apb(1'b1, `CUC_OFS_CMD, 32'h1);
        apb(1'b0, `CUC_OFS_STATUS, 32'h0);
        cmp("held status", 32'h79, rd);
    endtask
    task automatic t_down();
        apb(1'b1, `CUC_OFS_CTRL, 32'h2);
        wait_co();
        cmp("bottom", 32'h0, {28'h0, cnt});
        @(posedge i_clk);
        cmp("wrap down", 32'hf, {28'h0, cnt});
        cmp("carry one", 32'h1, {31'h0, link.carry_out_n});
        apb(1'b1, `CUC_OFS_CTRL, 32'h0);
    endtask
    task automatic t_div();
        int k;
        apb(1'b1, `CUC_OFS_PRESET, 32'h4);
        apb(1'b1, `CUC_OFS_CTRL, 32'h6);
        do @(posedge i_clk); while (div_tick !== 1'b1);
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (div_tick !== 1'b1);
        cmp("period", 32'h4, k);
        apb(1'b1, `CUC_OFS_PRESET, 32'h0);
        apb(1'b0, `CUC_OFS_PRESET, 32'h0);
        cmp("zero ratio kept", 32'h4, rd);
        apb(1'b1, `CUC_OFS_CTRL, 32'h0);
    endtask
    task automatic t_clr();
        apb(1'b1, `CUC_OFS_CMD, 32'h3);
        apb(1'b0, `CUC_OFS_STATUS, 32'h0);
        cmp("clear wins", 32'h30, rd);
        apb(1'b1, `CUC_OFS_STATUS, 32'h20);
        apb(1'b0, `CUC_OFS_STATUS, 32'h0);
        cmp("term cleared", 32'h10, rd);
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_up();
        t_down();
        t_div();
        t_clr();
        close_out();
    end
endmodule
